// [tb/bdpr_far_model.sv]
`timescale 1ns/1ns
`default_nettype none
module bdpr_far_model
(
    // far agents pulling the pins low
    input  wire logic primReq,
    input  wire logic secReq,
    // device side of the pins
    input  wire logic primOut_n,
    input  wire logic primOe,
    input  wire logic secOut_n,
    input  wire logic secOe,
    // wired levels, pulled up when nobody drives
    output logic      primLevel_n,
    output logic      secLevel_n
);
    assign primLevel_n = !primReq && !(primOe && !primOut_n);
    assign secLevel_n  = !secReq && !(secOe && !secOut_n);
endmodule : bdpr_far_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
    import bdpr_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] rd;
    bdpr_xfer_t  xfer = '0;
    logic        primReq = 1'b0;
    logic        secReq = 1'b0;
    logic        pPinN;
    logic        sPinN;
    logic        pOutN;
    logic        pOe;
    logic        sOutN;
    logic        sOe;
    logic        irq;
    int          err_count = 0;
    int          tests_run = 0;
    // well above the cycles that all scenarios together need
    localparam int WDOG_CYCLES = 20000;

    always #2 mclk = !mclk;

    bdpr_parity_report u_bdpr_parity_report (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .xfer(xfer), .primaryParityErrorPin_n_in(pPinN), .primaryParityErrorPin_n_out(pOutN),
        .primaryParityErrorPin_oe(pOe), .secondaryParityErrorPin_n_in(sPinN),
        .secondaryParityErrorPin_n_out(sOutN), .secondaryParityErrorPin_oe(sOe), .irq(irq));

    bdpr_far_model u_bdpr_far_model (.primReq(primReq), .secReq(secReq), .primOut_n(pOutN),
        .primOe(pOe), .secOut_n(sOutN), .secOe(sOe), .primLevel_n(pPinN), .secLevel_n(sPinN));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    task automatic pulse(input bdpr_xfer_t x, input logic pr, input logic sr);
        @(posedge mclk);
        xfer    <= x;
        primReq <= pr;
        secReq  <= sr;
        @(posedge mclk);
        xfer    <= '0;
        primReq <= 1'b0;
        secReq  <= 1'b0;
        #1;
    endtask : pulse

    task automatic test_reset();
        chk(32'({pOutN, pOe, sOutN, sOe, irq}), 32'h0000_0014);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0000_0000, rd);
            chk(rd, 32'h0000_0000);
        end
        $display("test_reset done");
    endtask : test_reset

    task automatic test_table();
        bdpr_xfer_t x;
        logic       pa;
        logic       sa;
        logic       pm;
        logic       sm;
        for (int en = 0; en < 4; en++)
            for (int k = 0; k < 3; k++)
                for (int u = 0; u < 2; u++)
                    for (int b = 0; b < 2; b++)
                    begin
                        apb(1'b1, BDPR_CTRL_OFS, 32'(en), rd);
                        x  = '{1'b1, bdpr_kind_t'(k), u[0], b[0], !b[0], 1'b0};
                        pa = en[0] && b[0] && ((k == 0) == u[0]);
                        sa = en[1] && !b[0] && ((k == 0) != u[0]);
                        pm = en[0] && b[0] && u[0];
                        sm = en[1] && !b[0] && !u[0];
                        pulse(x, 1'b0, 1'b0);
                        chk(32'({pOutN, pOe, sOutN, sOe}), 32'({!pa, pa, !sa, sa}));
                        apb(1'b0, BDPR_STAT_OFS, 32'h0000_0000, rd);
                        chk(rd, 32'({sm, pm}));
                        apb(1'b0, BDPR_INTST_OFS, 32'h0000_0000, rd);
                        chk(rd, 32'({sa, pa, sm, pm}));
                        apb(1'b1, BDPR_STAT_OFS, 32'h0000_0003, rd);
                        apb(1'b1, BDPR_INTCLR_OFS, 32'h0000_000F, rd);
                    end
        $display("test_table done");
    endtask : test_table

    task automatic test_forward();
        for (int en = 0; en < 4; en++)
        begin
            apb(1'b1, BDPR_CTRL_OFS, 32'(en), rd);
            pulse('{1'b1, BDPR_DELAYED_WR, 1'b0, 1'b0, 1'b1, 1'b1}, 1'b0, 1'b1);
            chk(32'({pOutN, pOe, sOe}), 32'({en != 3, en == 3, 1'b0}));
            pulse('{1'b1, BDPR_DELAYED_WR, 1'b1, 1'b1, 1'b0, 1'b1}, 1'b1, 1'b0);
            chk(32'({sOutN, sOe, pOe}), 32'({en != 3, en == 3, 1'b0}));
        end
        apb(1'b1, BDPR_STAT_OFS, 32'h0000_0003, rd);
        apb(1'b1, BDPR_INTCLR_OFS, 32'h0000_000F, rd);
        $display("test_forward done");
    endtask : test_forward

    task automatic test_sticky_irq();
        apb(1'b1, BDPR_INTEN_OFS, 32'h0000_0000, rd);
        pulse('{1'b1, BDPR_READ, 1'b1, 1'b1, 1'b0, 1'b0}, 1'b0, 1'b0);
        repeat (3) @(posedge mclk);
        #1;
        chk(32'(irq), 32'h0000_0000);
        apb(1'b1, BDPR_STAT_OFS, 32'h0000_0002, rd);
        apb(1'b0, BDPR_STAT_OFS, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0001);
        apb(1'b1, BDPR_INTEN_OFS, 32'h0000_0001, rd);
        chk(32'(irq), 32'h0000_0001);
        apb(1'b1, BDPR_INTCLR_OFS, 32'h0000_0001, rd);
        chk(32'(irq), 32'h0000_0000);
        apb(1'b0, BDPR_INTST_OFS, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0004);
        apb(1'b1, BDPR_STAT_OFS, 32'h0000_0001, rd);
        apb(1'b0, BDPR_STAT_OFS, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 8'h20, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
        chk(32'({pready, pslverr}), 32'h0000_0002);
        $display("test_sticky_irq done");
    endtask : test_sticky_irq

    task automatic test_midreset();
        apb(1'b1, BDPR_CTRL_OFS, 32'h0000_0003, rd);
        apb(1'b1, BDPR_INTEN_OFS, 32'h0000_000F, rd);
        pulse('{1'b1, BDPR_READ, 1'b1, 1'b1, 1'b0, 1'b0}, 1'b0, 1'b0);
        apb(1'b0, BDPR_STAT_OFS, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0001);
        chk(32'(irq), 32'h0000_0001);
        // reset in mid-run must drop sticky, enable and control state
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        #1;
        test_reset();
        $display("test_midreset done");
    endtask : test_midreset

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        #1;
        test_reset();
        test_table();
        test_forward();
        test_sticky_irq();
        test_midreset();
        finish_test();
    end

    // watchdog against a hung handshake
    initial
    begin
        repeat (WDOG_CYCLES) @(posedge mclk);
        err_count++;
        finish_test();
    end
endmodule : tb
`default_nettype wire

// [verilog/bdpr_parity_report.sv]
`timescale 1ns/1ns
`default_nettype none

// Function
// - primary master bit needs primary master, enable, error
// - primary bit only upstream primary-detected, enable set
// - secondary master bit needs secondary master, enable, error
// - secondary bit only downstream secondary-detected, enable set
// - primary pin only as write target/read initiator
// - primary pin on downstream delayed write forwards
// - primary pin asserts low for listed cases only
// - secondary pin only as write target/read initiator
// - secondary pin on upstream delayed write forwards
// - secondary pin asserts low for listed cases only
module bdpr_parity_report
    import bdpr_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // transfer in progress
    input  wire bdpr_xfer_t  xfer,
    // parity error pins, active low
    input  wire logic        primaryParityErrorPin_n_in,
    output logic             primaryParityErrorPin_n_out,
    output logic             primaryParityErrorPin_oe,
    input  wire logic        secondaryParityErrorPin_n_in,
    output logic             secondaryParityErrorPin_n_out,
    output logic             secondaryParityErrorPin_oe,
    // interrupt
    output logic             irq
);

    // ----------------------------------------
    // decode of the transfer
    // ----------------------------------------
    logic presp;
    logic sresp;
    logic isRd;
    logic isPw;
    logic isDw;
    logic up;
    logic dn;
    logic primMaster;
    logic secMaster;
    logic pPerrSeen;
    logic sPerrSeen;

    logic [1:0]           ctrl_ff;
    logic [1:0]           nxt_ctrl;
    logic [1:0]           stat_ff;
    logic [1:0]           nxt_stat;
    logic [BDPR_EV_W-1:0] intSt_ff;
    logic [BDPR_EV_W-1:0] nxt_intSt;
    logic [BDPR_EV_W-1:0] intEn_ff;
    logic [BDPR_EV_W-1:0] nxt_intEn;
    logic [31:0]          prdata_ff;
    logic [31:0]          nxt_prdata;
    logic                 pDrive_ff;
    logic                 nxt_pDrive;
    logic                 sDrive_ff;
    logic                 nxt_sDrive;

    assign presp      = ctrl_ff[BDPR_CTRL_PRESP_BIT];
    assign sresp      = ctrl_ff[BDPR_CTRL_SRESP_BIT];
    assign isRd       = xfer.active && (xfer.kind == BDPR_READ);
    assign isPw       = xfer.active && (xfer.kind == BDPR_POSTED_WR);
    assign isDw       = xfer.active && (xfer.kind == BDPR_DELAYED_WR);
    assign up         = xfer.upstream;
    assign dn         = !xfer.upstream;
    // upstream traffic makes the bridge master on primary, downstream on secondary
    assign primMaster = xfer.active && up;
    assign secMaster  = xfer.active && dn;
    assign pPerrSeen  = !primaryParityErrorPin_n_in;
    assign sPerrSeen  = !secondaryParityErrorPin_n_in;

    // ----------------------------------------
    // status set terms
    // ----------------------------------------
    logic setPmdp;
    logic setSmdp;

    always_comb
    begin
        // primary-detected error as master on primary, any upstream kind
        setPmdp = primMaster && presp && xfer.errPrim && (isRd || isPw || isDw);
        // secondary-detected error as master on secondary, any downstream kind
        setSmdp = secMaster && sresp && xfer.errSec && (isRd || isPw || isDw);
    end

    // ----------------------------------------
    // parity error pin drive
    // ----------------------------------------
    always_comb
    begin
        // primary: read initiator upstream, write target downstream
        nxt_pDrive = presp && xfer.errPrim && ((isRd && up) || ((isPw || isDw) && dn));
        // forward of a secondary-reported error on downstream delayed write
        if (isDw && dn && xfer.dwCompl && sPerrSeen && presp && sresp)
        begin
            nxt_pDrive = 1'b1;
        end
        // secondary: read initiator downstream, write target upstream
        nxt_sDrive = sresp && xfer.errSec && ((isRd && dn) || ((isPw || isDw) && up));
        if (isDw && up && xfer.dwCompl && pPerrSeen && presp && sresp)
        begin
            nxt_sDrive = 1'b1;
        end
    end

    assign primaryParityErrorPin_n_out   = !pDrive_ff;
    assign primaryParityErrorPin_oe      = pDrive_ff;
    assign secondaryParityErrorPin_n_out = !sDrive_ff;
    assign secondaryParityErrorPin_oe    = sDrive_ff;

    // ----------------------------------------
    // apb registers
    // ----------------------------------------
    logic wrEn;
    logic rdEn;
    logic [BDPR_EV_W-1:0] events;

    assign wrEn    = psel && penable && pwrite;
    assign rdEn    = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = prdata_ff;
    assign irq     = |(intSt_ff & intEn_ff);

    always_comb
    begin
        events                     = '0;
        events[BDPR_EV_PMDP_BIT]   = setPmdp;
        events[BDPR_EV_SMDP_BIT]   = setSmdp;
        events[BDPR_EV_PPERR_BIT]  = nxt_pDrive;
        events[BDPR_EV_SPERR_BIT]  = nxt_sDrive;
        nxt_ctrl   = ctrl_ff;
        nxt_stat   = stat_ff;
        nxt_intSt  = intSt_ff;
        nxt_intEn  = intEn_ff;
        nxt_prdata = prdata_ff;
        if (wrEn)
        begin
            case (paddr)
                BDPR_CTRL_OFS:   nxt_ctrl  = pwdata[1:0];
                BDPR_STAT_OFS:   nxt_stat  = stat_ff & ~pwdata[1:0];
                BDPR_INTEN_OFS:  nxt_intEn = pwdata[BDPR_EV_W-1:0];
                BDPR_INTCLR_OFS: nxt_intSt = intSt_ff & ~pwdata[BDPR_EV_W-1:0];
                default:         nxt_ctrl  = ctrl_ff;
            endcase
        end
        // set wins over a same-cycle clear
        nxt_stat[BDPR_STAT_PMDP_BIT] = nxt_stat[BDPR_STAT_PMDP_BIT] | setPmdp;
        nxt_stat[BDPR_STAT_SMDP_BIT] = nxt_stat[BDPR_STAT_SMDP_BIT] | setSmdp;
        nxt_intSt = nxt_intSt | events;
        if (rdEn)
        begin
            case (paddr)
                BDPR_CTRL_OFS:  nxt_prdata = {30'h0000_0000, ctrl_ff};
                BDPR_STAT_OFS:  nxt_prdata = {30'h0000_0000, stat_ff};
                BDPR_INTST_OFS: nxt_prdata = {28'h000_0000, intSt_ff};
                BDPR_INTEN_OFS: nxt_prdata = {28'h000_0000, intEn_ff};
                default:        nxt_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctrl_ff   <= BDPR_CTRL_RST;
            stat_ff   <= BDPR_STAT_RST;
            intSt_ff  <= BDPR_EV_RST;
            intEn_ff  <= BDPR_EV_RST;
            prdata_ff <= 32'h0000_0000;
            pDrive_ff <= 1'b0;
            sDrive_ff <= 1'b0;
        end
        else
        begin
            ctrl_ff   <= nxt_ctrl;
            stat_ff   <= nxt_stat;
            intSt_ff  <= nxt_intSt;
            intEn_ff  <= nxt_intEn;
            prdata_ff <= nxt_prdata;
            pDrive_ff <= nxt_pDrive;
            sDrive_ff <= nxt_sDrive;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_pmdp_cause;
        @(posedge mclk) disable iff (rst)
        $rose(stat_ff[BDPR_STAT_PMDP_BIT]) |-> $past(primMaster && presp && xfer.errPrim);
    endproperty
    a_pmdp_cause: assert property (p_pmdp_cause) else $error("primary master bit set without cause");

    property p_pmdp_set;
        @(posedge mclk) disable iff (rst)
        (xfer.active && up && presp && xfer.errPrim) |=> stat_ff[BDPR_STAT_PMDP_BIT];
    endproperty
    a_pmdp_set: assert property (p_pmdp_set) else $error("primary master bit not set");

    property p_smdp_cause;
        @(posedge mclk) disable iff (rst)
        $rose(stat_ff[BDPR_STAT_SMDP_BIT]) |-> $past(secMaster && sresp && xfer.errSec);
    endproperty
    a_smdp_cause: assert property (p_smdp_cause) else $error("secondary master bit set without cause");

    property p_smdp_set;
        @(posedge mclk) disable iff (rst)
        (xfer.active && dn && sresp && xfer.errSec) |=> stat_ff[BDPR_STAT_SMDP_BIT];
    endproperty
    a_smdp_set: assert property (p_smdp_set) else $error("secondary master bit not set");

    property p_pperr_en;
        @(posedge mclk) disable iff (rst)
        primaryParityErrorPin_oe |-> $past(presp);
    endproperty
    a_pperr_en: assert property (p_pperr_en) else $error("primary pin driven with enable clear");

    property p_pperr_fwd;
        @(posedge mclk) disable iff (rst)
        (isDw && dn && xfer.dwCompl && sPerrSeen && presp && sresp) |=> !primaryParityErrorPin_n_out;
    endproperty
    a_pperr_fwd: assert property (p_pperr_fwd) else $error("secondary error not forwarded");

    property p_pperr_up_wr;
        @(posedge mclk) disable iff (rst)
        ((isPw || isDw) && up && !xfer.dwCompl) |=> primaryParityErrorPin_n_out;
    endproperty
    a_pperr_up_wr: assert property (p_pperr_up_wr) else $error("primary pin on upstream write");

    property p_sperr_en;
        @(posedge mclk) disable iff (rst)
        secondaryParityErrorPin_oe |-> $past(sresp);
    endproperty
    a_sperr_en: assert property (p_sperr_en) else $error("secondary pin driven with enable clear");

    property p_sperr_fwd;
        @(posedge mclk) disable iff (rst)
        (isDw && up && xfer.dwCompl && pPerrSeen && presp && sresp) |=> !secondaryParityErrorPin_n_out;
    endproperty
    a_sperr_fwd: assert property (p_sperr_fwd) else $error("primary error not forwarded");

    property p_sperr_dn_wr;
        @(posedge mclk) disable iff (rst)
        ((isPw || isDw) && dn && !xfer.dwCompl) |=> secondaryParityErrorPin_n_out;
    endproperty
    a_sperr_dn_wr: assert property (p_sperr_dn_wr) else $error("secondary pin on downstream write");

    property p_sticky;
        @(posedge mclk) disable iff (rst)
        (stat_ff[BDPR_STAT_PMDP_BIT] && !(wrEn && paddr == BDPR_STAT_OFS)) |=> stat_ff[BDPR_STAT_PMDP_BIT];
    endproperty
    a_sticky: assert property (p_sticky) else $error("status bit lost without clear");

    property p_pmdp_not_master;
        @(posedge mclk) disable iff (rst)
        (!stat_ff[BDPR_STAT_PMDP_BIT] && !primMaster) |=> !stat_ff[BDPR_STAT_PMDP_BIT];
    endproperty
    a_pmdp_not_master: assert property (p_pmdp_not_master) else $error("primary bit set off master");

    property p_pmdp_resp_off;
        @(posedge mclk) disable iff (rst)
        (!stat_ff[BDPR_STAT_PMDP_BIT] && !presp) |=> !stat_ff[BDPR_STAT_PMDP_BIT];
    endproperty
    a_pmdp_resp_off: assert property (p_pmdp_resp_off) else $error("primary bit set with enable clear");

    property p_smdp_not_master;
        @(posedge mclk) disable iff (rst)
        (!stat_ff[BDPR_STAT_SMDP_BIT] && !secMaster) |=> !stat_ff[BDPR_STAT_SMDP_BIT];
    endproperty
    a_smdp_not_master: assert property (p_smdp_not_master) else $error("secondary bit set off master");

    property p_smdp_resp_off;
        @(posedge mclk) disable iff (rst)
        (!stat_ff[BDPR_STAT_SMDP_BIT] && !sresp) |=> !stat_ff[BDPR_STAT_SMDP_BIT];
    endproperty
    a_smdp_resp_off: assert property (p_smdp_resp_off) else $error("secondary bit set with enable clear");

    property p_pperr_rd_up;
        @(posedge mclk) disable iff (rst)
        (isRd && up && presp && xfer.errPrim) |=> primaryParityErrorPin_oe;
    endproperty
    a_pperr_rd_up: assert property (p_pperr_rd_up) else $error("primary pin missed on upstream read");

    property p_pperr_wr_dn;
        @(posedge mclk) disable iff (rst)
        ((isPw || isDw) && dn && presp && xfer.errPrim) |=> primaryParityErrorPin_oe;
    endproperty
    a_pperr_wr_dn: assert property (p_pperr_wr_dn) else $error("primary pin missed on downstream write");

    property p_sperr_rd_dn;
        @(posedge mclk) disable iff (rst)
        (isRd && dn && sresp && xfer.errSec) |=> secondaryParityErrorPin_oe;
    endproperty
    a_sperr_rd_dn: assert property (p_sperr_rd_dn) else $error("secondary pin missed on downstream read");

    property p_sperr_wr_up;
        @(posedge mclk) disable iff (rst)
        ((isPw || isDw) && up && sresp && xfer.errSec) |=> secondaryParityErrorPin_oe;
    endproperty
    a_sperr_wr_up: assert property (p_sperr_wr_up) else $error("secondary pin missed on upstream write");

    property p_pperr_idle;
        @(posedge mclk) disable iff (rst)
        !xfer.active |=> !primaryParityErrorPin_oe;
    endproperty
    a_pperr_idle: assert property (p_pperr_idle) else $error("primary pin driven with no transfer");

    property p_sperr_idle;
        @(posedge mclk) disable iff (rst)
        !xfer.active |=> !secondaryParityErrorPin_oe;
    endproperty
    a_sperr_idle: assert property (p_sperr_idle) else $error("secondary pin driven with no transfer");

    property p_pperr_rd_dn;
        @(posedge mclk) disable iff (rst)
        (isRd && dn) |=> !primaryParityErrorPin_oe;
    endproperty
    a_pperr_rd_dn: assert property (p_pperr_rd_dn) else $error("primary pin on downstream read");

    property p_sperr_rd_up;
        @(posedge mclk) disable iff (rst)
        (isRd && up) |=> !secondaryParityErrorPin_oe;
    endproperty
    a_sperr_rd_up: assert property (p_sperr_rd_up) else $error("secondary pin on upstream read");

    property p_reset_clear;
        @(posedge mclk)
        rst |=> (stat_ff == BDPR_STAT_RST) && !primaryParityErrorPin_oe && !secondaryParityErrorPin_oe;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("state not cleared by reset");

endmodule : bdpr_parity_report

`default_nettype wire

// [verilog/bdpr_pkg.sv]
package bdpr_pkg;

    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] BDPR_CTRL_OFS   = 8'h00;
    localparam logic [7:0] BDPR_STAT_OFS   = 8'h04;
    localparam logic [7:0] BDPR_INTST_OFS  = 8'h08;
    localparam logic [7:0] BDPR_INTEN_OFS  = 8'h0C;
    localparam logic [7:0] BDPR_INTCLR_OFS = 8'h10;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int BDPR_CTRL_PRESP_BIT = 0;
    localparam int BDPR_CTRL_SRESP_BIT = 1;
    localparam int BDPR_STAT_PMDP_BIT  = 0;
    localparam int BDPR_STAT_SMDP_BIT  = 1;
    localparam int BDPR_EV_PMDP_BIT    = 0;
    localparam int BDPR_EV_SMDP_BIT    = 1;
    localparam int BDPR_EV_PPERR_BIT   = 2;
    localparam int BDPR_EV_SPERR_BIT   = 3;
    localparam int BDPR_EV_W           = 4;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [1:0]          BDPR_CTRL_RST  = 2'h0;
    localparam logic [1:0]          BDPR_STAT_RST  = 2'h0;
    localparam logic [BDPR_EV_W-1:0] BDPR_EV_RST   = 4'h0;

    // ----------------------------------------
    // transfer description
    // ----------------------------------------
    typedef enum logic [1:0] {BDPR_READ, BDPR_POSTED_WR, BDPR_DELAYED_WR} bdpr_kind_t;

    typedef struct packed {
        logic       active;     // transfer is in its data phase
        bdpr_kind_t kind;
        logic       upstream;   // 1 upstream, 0 downstream
        logic       errPrim;    // data parity error found on primary bus
        logic       errSec;     // data parity error found on secondary bus
        logic       dwCompl;    // delayed write completing on target bus
    } bdpr_xfer_t;

endpackage : bdpr_pkg
